// ---- design/sscm_consts.vh ----
`ifndef SSCM_CONSTS_VH
`define SSCM_CONSTS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SSCM_ADDR_W 4
`define SSCM_OFS_CLK 4'h0
`define SSCM_OFS_SETTLE 4'h1
`define SSCM_OFS_MASK 4'h2
`define SSCM_OFS_STAT 4'h3
`define SSCM_OFS_STOP 4'h4
`define SSCM_OFS_PORT 4'h5
`define SSCM_OFS_DIR 4'h6
`define SSCM_OFS_PERI 4'h7
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SSCM_CLK_DIV_LSB 0
`define SSCM_CLK_DIV_MSB 2
`define SSCM_CLK_OSC_STOP 3
`define SSCM_CLK_SUB_SEL 4
`define SSCM_PERI_RTO_TRIG 0
`define SSCM_PERI_TMR_STOP_EN 1
`define SSCM_PERI_UART_EXT 2
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SSCM_CLK_RST 5'h03
`define SSCM_DIV_RST 3'h3
`define SSCM_SETTLE_RST 3'h4
`define SSCM_MASK_RST 2'h0
`define SSCM_PERI_RST 3'h0
// ----------------------------------------
// Timing counts in main clock periods
// ----------------------------------------
`define SSCM_WAIT_0 17'h00400
`define SSCM_WAIT_1 17'h00800
`define SSCM_WAIT_2 17'h01000
`define SSCM_WAIT_3 17'h02000
`define SSCM_WAIT_4 17'h08000
`define SSCM_WAIT_5 17'h10000
`define SSCM_WAIT_RESET 17'h08000
`endif

// ---- design/sscm_settle_cnt.v ----
`include "sscm_consts.vh"
module sscm_settle_cnt #(
  parameter CNT_W = 17
) (
  input wire core_clk,
  input wire reset_n,
  input wire start,
  input wire [CNT_W-1:0] limit,
  output wire busy,
  output wire done
);
  reg [CNT_W-1:0] count_r;
  reg [CNT_W-1:0] limit_r;
  reg run_r;
  reg done_r;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= {CNT_W{1'b0}};
      limit_r <= {CNT_W{1'b0}};
      run_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start) begin
        count_r <= {CNT_W{1'b0}};
        // The limit is latched so the reset wait survives the boot flag.
        limit_r <= limit;
        run_r <= 1'b1;
      end else if (run_r) begin
        if (count_r + 1'b1 >= limit_r) begin
          run_r <= 1'b0;
          done_r <= 1'b1;
        end
        count_r <= count_r + 1'b1;
      end
    end
  end
  assign busy = run_r | start;
  assign done = done_r;
endmodule

// ---- design/sscm_clk_div.v ----
module sscm_clk_div (
  input wire core_clk,
  input wire reset_n,
  input wire [2:0] div_sel,
  output wire tick
);
  reg [6:0] div_r;
  // Tick once per 2^div_sel main clocks; capped at 64.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_r <= 7'h00;
    end else begin
      div_r <= div_r + 7'h01;
    end
  end
  function div_hit;
    input [6:0] cnt;
    input [2:0] sel;
    reg [6:0] mask;
    begin
      mask = (7'h01 << (sel > 3'h6 ? 3'h6 : sel)) - 7'h01;
      div_hit = ((cnt & mask) == 7'h00);
    end
  endfunction
  assign tick = div_hit(div_r, div_sel);
endmodule

// ---- design/sscm_top.v ----
`include "sscm_consts.vh"
module sscm_top #(
  parameter PORT_W = 8,
  parameter IRQ_W = 2
) (
  input wire core_clk,
  input wire reset_n,
  input wire [`SSCM_ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rdata,
  input wire [IRQ_W-1:0] irq_req,
  input wire nmi_req,
  input wire subclk_tick,
  output wire cpu_clk_en,
  output wire sys_clk_tick,
  output wire main_osc_en,
  output wire use_subclock,
  output wire in_stop,
  output reg [PORT_W-1:0] port_out,
  output reg [PORT_W-1:0] port_dir,
  output wire dac_write_en,
  output wire rto_buffer_write_en,
  output wire rto_run,
  output wire uart_run
);
  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  reg [2:0] sysclk_divider_bits_r;
  reg main_osc_stop_r;
  reg subclock_select_r;
  reg [2:0] osc_settle_select_r;
  reg maskable_irq_block_r;
  reg nmi_block_r;
  reg [2:0] peri_cfg_r;
  reg stop_r;
  reg settle_r;
  reg boot_r;
  reg [PORT_W-1:0] port_nxt;
  wire settle_busy;
  wire settle_done;
  wire div_tick;
  wire wake_irq;
  wire cpu_wr;
  wire [16:0] settle_limit;

  function [16:0] settle_count;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: settle_count = `SSCM_WAIT_0;
        3'h1: settle_count = `SSCM_WAIT_1;
        3'h2: settle_count = `SSCM_WAIT_2;
        3'h3: settle_count = `SSCM_WAIT_3;
        3'h4: settle_count = `SSCM_WAIT_4;
        3'h5: settle_count = `SSCM_WAIT_5;
        default: settle_count = `SSCM_WAIT_5;
      endcase
    end
  endfunction

  // The CPU is halted in stop and during settling, so no write lands.
  // writes blocked while halted.
  assign cpu_wr = wr_en & cpu_clk_en;

  assign wake_irq = (|irq_req & ~maskable_irq_block_r) |
                    (nmi_req & ~nmi_block_r);

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sysclk_divider_bits_r <= `SSCM_DIV_RST;
      main_osc_stop_r <= 1'b0;
      subclock_select_r <= 1'b0;
      osc_settle_select_r <= `SSCM_SETTLE_RST;
      maskable_irq_block_r <= 1'b0;
      nmi_block_r <= 1'b0;
      peri_cfg_r <= `SSCM_PERI_RST;
    end else if (cpu_wr) begin
      case (addr)
        `SSCM_OFS_CLK: begin
          sysclk_divider_bits_r <= wdata[`SSCM_CLK_DIV_MSB:
                                         `SSCM_CLK_DIV_LSB];
          main_osc_stop_r <= wdata[`SSCM_CLK_OSC_STOP];
          subclock_select_r <= wdata[`SSCM_CLK_SUB_SEL];
        end
        `SSCM_OFS_SETTLE: osc_settle_select_r <= wdata[2:0];
        `SSCM_OFS_MASK: begin
          maskable_irq_block_r <= wdata[0];
          nmi_block_r <= wdata[1];
        end
        `SSCM_OFS_PERI: peri_cfg_r <= wdata[2:0];
        default: peri_cfg_r <= peri_cfg_r;
      endcase
    end
  end

  // ----------------------------------------
  // Stop and settle sequencing
  // ----------------------------------------
  assign settle_limit = boot_r ? `SSCM_WAIT_RESET :
                        settle_count(osc_settle_select_r);

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stop_r <= 1'b0;
      settle_r <= 1'b0;
      boot_r <= 1'b1;
    end else begin
      boot_r <= 1'b0;
      if (cpu_wr && addr == `SSCM_OFS_STOP && wdata[0]) begin
        stop_r <= 1'b1;
      end else if (stop_r && wake_irq) begin
        stop_r <= 1'b0;
        settle_r <= 1'b1;
      end else if (boot_r) begin
        settle_r <= 1'b1;
      end else if (settle_done) begin
        settle_r <= 1'b0;
      end
    end
  end

  sscm_settle_cnt #(
    .CNT_W(17)
  ) u_settle (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .start((stop_r & wake_irq) | boot_r),
    .limit(settle_limit),
    .busy(settle_busy),
    .done(settle_done)
  );

  sscm_clk_div u_div (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .div_sel(sysclk_divider_bits_r),
    .tick(div_tick)
  );

  // CPU clock gated until count ends.
  assign cpu_clk_en = ~stop_r & ~settle_r & ~boot_r;
  assign in_stop = stop_r;
  assign use_subclock = subclock_select_r;
  assign sys_clk_tick = cpu_clk_en &
                        (subclock_select_r ? subclk_tick : div_tick);
  assign main_osc_en = ~stop_r & ~main_osc_stop_r;

  // DAC value needs a running CPU.
  assign dac_write_en = cpu_clk_en;
  assign rto_buffer_write_en = cpu_clk_en;
  // RTO needs both timer trigger and timer stop enable in stop.
  assign rto_run = ~stop_r | (peri_cfg_r[`SSCM_PERI_RTO_TRIG] &
                              peri_cfg_r[`SSCM_PERI_TMR_STOP_EN]);
  // UART needs external baud in stop.
  assign uart_run = ~stop_r | peri_cfg_r[`SSCM_PERI_UART_EXT];

  // ----------------------------------------
  // Ports
  // ----------------------------------------
  // port state held during stop.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_out <= {PORT_W{1'b0}};
      port_dir <= {PORT_W{1'b0}};
    end else if (cpu_wr && addr == `SSCM_OFS_PORT) begin
      port_out <= wdata[PORT_W-1:0];
    end else if (cpu_wr && addr == `SSCM_OFS_DIR) begin
      port_dir <= wdata[PORT_W-1:0];
    end
  end

  // ----------------------------------------
  // Read-back
  // ----------------------------------------
  always @* begin
    case (addr)
      `SSCM_OFS_CLK: port_nxt = {3'h0, subclock_select_r, main_osc_stop_r,
                                 sysclk_divider_bits_r};
      `SSCM_OFS_SETTLE: port_nxt = {5'h00, osc_settle_select_r};
      `SSCM_OFS_MASK: port_nxt = {6'h00, nmi_block_r, maskable_irq_block_r};
      `SSCM_OFS_STAT: port_nxt = {4'h0, settle_busy, settle_r, stop_r,
                                  subclock_select_r};
      `SSCM_OFS_PORT: port_nxt = port_out;
      `SSCM_OFS_DIR: port_nxt = port_dir;
      `SSCM_OFS_PERI: port_nxt = {5'h00, peri_cfg_r};
      default: port_nxt = 8'h00;
    endcase
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      rdata <= port_nxt;
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule

// ---- sim/sscm_top_properties.sv ----
`include "sscm_consts.vh"
module sscm_props #(
  parameter PORT_W = 8
) (
  input wire core_clk,
  input wire reset_n,
  input wire [`SSCM_ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire subclk_tick,
  input wire cpu_clk_en,
  input wire sys_clk_tick,
  input wire main_osc_en,
  input wire use_subclock,
  input wire in_stop,
  input wire [PORT_W-1:0] port_out,
  input wire [PORT_W-1:0] port_dir,
  input wire dac_write_en,
  input wire rto_buffer_write_en
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Writes only count while the CPU runs, as the bus refuses them otherwise.
  wire ctrl_wr = wr_en && cpu_clk_en && addr == `SSCM_OFS_CLK;
  stop_gate_a: assert property (
    in_stop |-> !cpu_clk_en) else $error("cpu clock on in stop");
  wake_gate_a: assert property (
    $fell(in_stop) |-> !cpu_clk_en [*8]) else $error("no settle wait");
  port_hold_a: assert property (
    in_stop && $past(in_stop) |-> $stable(port_out) && $stable(port_dir))
    else $error("port changed in stop");
  dac_freeze_a: assert property (
    in_stop |-> !dac_write_en) else $error("dac write in stop");
  rto_freeze_a: assert property (
    in_stop |-> !rto_buffer_write_en) else $error("rto write in stop");
  sub_enter_a: assert property (
    ctrl_wr && wdata[4] |=> use_subclock) else $error("no subclock entry");
  sub_leave_a: assert property (
    ctrl_wr && !wdata[4] |=> !use_subclock) else $error("no subclock exit");
  osc_stop_a: assert property (
    ctrl_wr && wdata[3] |=> !main_osc_en) else $error("oscillator runs");
  sub_tick_a: assert property (
    use_subclock && cpu_clk_en |-> sys_clk_tick == subclk_tick)
    else $error("tick not from subclock");
endmodule
bind sscm_top sscm_props #(.PORT_W(PORT_W)) sscm_props_i (
  .core_clk(core_clk),
  .reset_n(reset_n),
  .addr(addr),
  .wdata(wdata),
  .wr_en(wr_en),
  .subclk_tick(subclk_tick),
  .cpu_clk_en(cpu_clk_en),
  .sys_clk_tick(sys_clk_tick),
  .main_osc_en(main_osc_en),
  .use_subclock(use_subclock),
  .in_stop(in_stop),
  .port_out(port_out),
  .port_dir(port_dir),
  .dac_write_en(dac_write_en),
  .rto_buffer_write_en(rto_buffer_write_en)
);

// ---- sim/sscm_tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, reset_n = 0, wr_en = 0, rd_en = 0, nmi_req = 0;
  logic subclk_tick = 0;
  logic [3:0] addr = 0, sc = 0;
  logic [7:0] wdata = 0, rv;
  logic [1:0] irq_req = 0;
  wire [7:0] rdata, port_out, port_dir;
  wire cpu_clk_en, sys_clk_tick, main_osc_en, use_subclock, in_stop;
  wire dac_write_en, rto_buffer_write_en, rto_run, uart_run;
  int n_fail = 0, n_tests = 0, n;
  // ----------------------------------------
  // Rows: write flag, address, data, value read back
  // ----------------------------------------
  logic [20:0] rows [0:11] = '{21'h000003, 21'h010004, 21'h020000,
    21'h070000, 21'h0F0000, 21'h155A5A, 21'h16A5A5, 21'h120101,
    21'h170202, 21'h110000, 21'h1F7700, 21'h030000};
  sscm_top sscm_top_i (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rdata(rdata),
    .irq_req(irq_req),
    .nmi_req(nmi_req),
    .subclk_tick(subclk_tick),
    .cpu_clk_en(cpu_clk_en),
    .sys_clk_tick(sys_clk_tick),
    .main_osc_en(main_osc_en),
    .use_subclock(use_subclock),
    .in_stop(in_stop),
    .port_out(port_out),
    .port_dir(port_dir),
    .dac_write_en(dac_write_en),
    .rto_buffer_write_en(rto_buffer_write_en),
    .rto_run(rto_run),
    .uart_run(uart_run)
  );
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    sc <= sc + 4'h1;
    subclk_tick <= sc == 4'hF;
  end
  task test_done;
    $display("checks %0d errors %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
    @(negedge core_clk);
  endtask
  task rd(input logic [3:0] a);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    @(negedge core_clk);
    rv = rdata;
  endtask
  // A hung settle wait ends the run instead of stalling it.
  task wait_run(input int lim);
    n = 0;
    while (cpu_clk_en !== 1'b1 && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= lim) begin
      chk("cpu_clk_en", 1, 0);
      test_done();
    end
  endtask
  task tick_cnt(input int e);
    n = 0;
    repeat (64) begin
      @(negedge core_clk);
      n += sys_clk_tick;
    end
    chk("ticks", e, n);
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    wait_run(40000);
    chk("boot_wait", 1, n >= 32766 && n <= 32772);
    foreach (rows[i]) begin
      if (rows[i][20])
        wr(rows[i][19:16], rows[i][15:8]);
      rd(rows[i][19:16]);
      chk("reg_read", rows[i][7:0], rv);
    end
    tick_cnt(8);
    wr(4'h0, 8'h01);
    tick_cnt(32);
    wr(4'h4, 8'h01);
    @(posedge core_clk);
    irq_req <= 2'h3;
    repeat (20) @(negedge core_clk);
    chk("stop_masked", 1, in_stop);
    chk("rto_run", 0, rto_run);
    chk("uart_run", 0, uart_run);
    wr(4'h5, 8'h00);
    chk("port_out", 8'h5A, port_out);
    chk("port_dir", 8'hA5, port_dir);
    @(posedge core_clk);
    nmi_req <= 1'b1;
    irq_req <= 2'h0;
    wait_run(2000);
    chk("wake_wait", 1, n >= 1024 && n <= 1032);
    @(posedge core_clk);
    nmi_req <= 1'b0;
    rd(4'h6);
    chk("dir_kept", 8'hA5, rv);
    wr(4'h7, 8'h07);
    wr(4'h2, 8'h00);
    wr(4'h4, 8'h01);
    repeat (4) @(negedge core_clk);
    chk("rto_run", 1, rto_run);
    chk("uart_run", 1, uart_run);
    @(posedge core_clk);
    irq_req <= 2'h1;
    wait_run(2000);
    chk("irq_wake", 1, n >= 1024 && n <= 1032);
    @(posedge core_clk);
    irq_req <= 2'h0;
    wr(4'h0, 8'h11);
    chk("sub_on", 1, use_subclock);
    tick_cnt(4);
    wr(4'h0, 8'h19);
    chk("osc_off", 0, main_osc_en);
    wr(4'h0, 8'h11);
    wr(4'h0, 8'h01);
    chk("sub_off", 0, use_subclock);
    wr(4'h0, 8'h11);
    @(posedge core_clk);
    reset_n <= 1'b0;
    @(negedge core_clk);
    chk("sub_reset", 0, use_subclock);
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    wait_run(40000);
    chk("reset_wait", 1, n >= 32766 && n <= 32772);
    test_done();
  end
endmodule
